// ---- include/uhor_pkg.sv ----
package uhor_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_ADDR        = 32'h30002c00;
  localparam logic [31:0] ADDR_VERSION     = 32'h30002c00;
  localparam logic [31:0] ADDR_CONTROL     = 32'h30002c04;
  localparam logic [31:0] ADDR_COMMAND     = 32'h30002c08;
  localparam logic [31:0] ADDR_EV_STATUS   = 32'h30002c0c;
  localparam logic [31:0] ADDR_EV_ENABLE   = 32'h30002c10;
  localparam logic [31:0] ADDR_EV_DISABLE  = 32'h30002c14;
  localparam logic [31:0] ADDR_COMM_AREA   = 32'h30002c18;
  localparam logic [31:0] ADDR_PER_CUR     = 32'h30002c1c;
  localparam logic [31:0] ADDR_CTRL_HEAD   = 32'h30002c20;
  localparam logic [31:0] ADDR_CTRL_CUR    = 32'h30002c24;
  localparam logic [31:0] ADDR_BULK_HEAD   = 32'h30002c28;
  localparam logic [31:0] ADDR_BULK_CUR    = 32'h30002c2c;
  localparam logic [31:0] ADDR_DONE_HEAD   = 32'h30002c30;
  localparam logic [31:0] ADDR_FR_INTERVAL = 32'h30002c34;
  localparam logic [31:0] ADDR_FR_LEFT     = 32'h30002c38;
  localparam logic [31:0] ADDR_FR_COUNT    = 32'h30002c3c;
  localparam logic [31:0] ADDR_PER_BEGIN   = 32'h30002c40;
  localparam logic [31:0] ADDR_LS_THRESH   = 32'h30002c44;
  localparam logic [31:0] ADDR_HUB_DESC_A  = 32'h30002c48;
  localparam logic [31:0] ADDR_HUB_DESC_B  = 32'h30002c4c;
  localparam logic [31:0] ADDR_HUB_STATE   = 32'h30002c50;
  localparam logic [31:0] ADDR_PORT_FIRST  = 32'h30002c54;
  localparam int          PORT_COUNT       = 2;
  localparam int          REG_COUNT        = 21 + PORT_COUNT;
  localparam int          IDX_W            = 5;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          VERSION_LSB      = 8;
  // Arbitrary value
  localparam logic [23:0] VERSION_VALUE    = 24'h000001;
  localparam int          CTL_W            = 11;
  localparam int          CTL_FS_LSB       = 6;
  localparam int          CTL_IR_BIT       = 8;
  localparam int          CTL_RWC_BIT      = 9;
  localparam logic [10:0] CTL_KEEP_MASK    = 11'h300;
  localparam logic [1:0]  FS_RESET         = 2'h0;
  localparam logic [1:0]  FS_RESUME        = 2'h1;
  localparam logic [1:0]  FS_OPER          = 2'h2;
  localparam logic [1:0]  FS_SUSPEND       = 2'h3;
  localparam int          CMD_RESET_BIT    = 0;
  localparam int          CMD_CLF_BIT      = 1;
  localparam int          CMD_BLF_BIT      = 2;
  localparam int          CMD_OCR_BIT      = 3;
  localparam int          EV_SO            = 0;
  localparam int          EV_WDH           = 1;
  localparam int          EV_SF            = 2;
  localparam int          EV_RD            = 3;
  localparam int          EV_UE            = 4;
  localparam int          EV_FNO           = 5;
  localparam int          EV_RHSC          = 6;
  localparam int          EV_OC            = 30;
  localparam int          EV_MASTER        = 31;
  localparam logic [31:0] EV_MASK          = 32'h4000007f;
  localparam logic [31:0] EN_MASK          = 32'hc000007f;
  localparam logic [31:0] COMM_AREA_MASK   = 32'hffffff00;
  localparam logic [31:0] DESC_PTR_MASK    = 32'hfffffff0;
  localparam logic [31:0] HUB_DESC_A_MASK  = 32'hff001f00;
  localparam int          FI_W             = 14;
  localparam int          PKT_W            = 15;
  localparam int          PKT_LSB          = 16;
  localparam int          TOGGLE_BIT       = 31;
  localparam int          FN_W             = 16;
  localparam int          LS_W             = 11;
  localparam logic [13:0] FI_RESET         = 14'h2edf;
  localparam logic [14:0] PKT_RESET        = 15'h0000;
  localparam logic [13:0] PER_RESET        = 14'h0000;
  localparam logic [10:0] LS_RESET         = 11'h628;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLOCK_PERIOD_NS  = 20;
  localparam int          START_DELAY_NS   = 1000000;
  localparam int          START_DELAY_CYC  = START_DELAY_NS / CLOCK_PERIOD_NS;
  localparam logic [4:0]  BIT_STEP         = 5'h06;
  localparam logic [4:0]  BIT_MODULO       = 5'h19;
endpackage

// ---- rtl/uhor_frame_timer.sv ----
`timescale 1ns/1ps
module uhor_frame_timer #(
  parameter int START_DELAY = uhor_pkg::START_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Control
  input  wire logic        run,
  input  wire logic [13:0] interval,
  input  wire logic        intervalToggle,
  // Frame state
  output logic      [13:0] remaining_q,
  output logic             remToggle_q,
  output logic      [15:0] frameNum_q,
  output logic             sofPulse_q
);
  // ----------------------------------------------------------------
  // Bit time enable, 12 MHz from 50 MHz
  // ----------------------------------------------------------------
  logic [4:0]  acc_q;
  logic [19:0] delay_q;
  logic        runPrev_q;
  logic        started_q;
  wire  [4:0]  accSum   = acc_q + uhor_pkg::BIT_STEP;
  wire         bitTick  = accSum >= uhor_pkg::BIT_MODULO;
  wire  [4:0]  accNext  = bitTick ? accSum - uhor_pkg::BIT_MODULO : accSum;
  wire         runRise  = run && !runPrev_q;
  wire         startNow = run && !runRise && !started_q && delay_q == 20'h00000;
  wire         wrap     = started_q && bitTick && remaining_q == 14'h0000;
  wire         newFrame = startNow || wrap;

  always_ff @(posedge clock) begin
    if (reset) begin
      acc_q     <= 5'h00;
      runPrev_q <= 1'b0;
    end else begin
      acc_q     <= accNext;
      runPrev_q <= run;
    end
  end

  // ----------------------------------------------------------------
  // Start delay and frame counters
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      started_q <= 1'b0;
      delay_q   <= 20'h00000;
    end else if (runRise) begin
      delay_q   <= 20'(START_DELAY - 1);
    end else if (!started_q && delay_q != 20'h00000) begin
      delay_q   <= delay_q - 20'h00001;
    end else if (startNow) begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      remaining_q <= 14'h0000;
      remToggle_q <= 1'b0;
      frameNum_q  <= 16'h0000;
      sofPulse_q  <= 1'b0;
    end else begin
      sofPulse_q <= newFrame;
      if (newFrame) begin
        remaining_q <= interval;
        remToggle_q <= intervalToggle;
        frameNum_q  <= frameNum_q + 16'h0001;
      end else if (started_q && bitTick) begin
        remaining_q <= remaining_q - 14'h0001;
      end
    end
  end
endmodule

// ---- rtl/uhor_regs.sv ----
`timescale 1ns/1ps
// Functional notes
// - Each operational register is one 32-bit word.
// - Version word is read-only; bits 31:8 hold the interface version.
// - Frame interval holds 14-bit bit-time count and 15-bit packet limit.
// - Frame time left counts down bit times in the current frame.
// - Frame count is a 16-bit counter advanced each frame.
// - Periodic list may not start before the periodic begin point.
// - 11-bit threshold decides if an 8-byte slow packet still fits.
// - Event status records every interrupt-capable event.
// - Only enabled events may raise the interrupt.
// - Writing ones to event disable clears those enable bits.
// - Command word takes software commands; reset goes out as softReset_q, the rest are held until cleared.
// - Comm area pointer holds the shared area address.
// - Periodic current pointer shows the descriptor being processed.
// - Control and bulk lists each have head and current pointers.
// - Bulk list served round-robin; current bulk pointer kept updated.
// - Completed queue head holds the last finished descriptor address.
// - Hub state: status in low half, change flags in high half.
// - One port state word per port from the first port address.
// - Registers sit at consecutive words from the base address.
// - Functional state: 00 reset, 01 resume, 10 operational, 11 suspend.
// - Frames begin 1 ms after entering operational.
module uhor_regs #(
  parameter int START_DELAY = uhor_pkg::START_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Register port
  input  wire logic [31:0] regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata_q,
  // List engine updates
  input  wire logic        perCurWe,
  input  wire logic        ctrlCurWe,
  input  wire logic        bulkCurWe,
  input  wire logic        doneWe,
  input  wire logic [31:0] engineAddr,
  input  wire logic        clfClear,
  input  wire logic        blfClear,
  input  wire logic        ownershipTaken,
  // Events
  input  wire logic        overrunEvent,
  input  wire logic        errorEvent,
  input  wire logic        resumeDetected,
  // Root hub
  input  wire logic [15:0] hubStatusIn,
  input  wire logic [15:0] hubChangeIn,
  input  wire logic [31:0] portStatusIn,
  input  wire logic [31:0] portChangeIn,
  output logic      [15:0] hubCmd_q,
  output logic      [31:0] portCmd_q,
  // Controller state
  output logic      [10:0] control_q,
  output logic             softReset_q,
  output logic             irq_q,
  output logic             sofPulse_q,
  output logic             periodicAllowed_q,
  output logic             slowCommitAllowed_q,
  output logic      [31:0] commArea_q,
  output logic      [31:0] ctrlHead_q,
  output logic      [31:0] bulkHead_q,
  output logic      [31:0] bulkCur_q
);
  localparam int NP = uhor_pkg::PORT_COUNT;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire  [31:0] offset  = regAddr - uhor_pkg::BASE_ADDR;
  wire  [29:0] wordIdx = offset[31:2];
  wire         hit     = offset[1:0] == 2'h0 && wordIdx < 30'(uhor_pkg::REG_COUNT);
  logic [uhor_pkg::REG_COUNT-1:0] wrSel;
  logic [31:0] word [uhor_pkg::REG_COUNT];

  genvar gi;
  generate
    for (gi = 0; gi < uhor_pkg::REG_COUNT; gi++) begin : g_sel
      assign wrSel[gi] = regWrite && hit && wordIdx == 30'(gi);
    end
  endgenerate

  wire wrCtl  = wrSel[(uhor_pkg::ADDR_CONTROL - uhor_pkg::BASE_ADDR) >> 2];
  wire wrCmd  = wrSel[(uhor_pkg::ADDR_COMMAND - uhor_pkg::BASE_ADDR) >> 2];
  wire wrSts  = wrSel[(uhor_pkg::ADDR_EV_STATUS - uhor_pkg::BASE_ADDR) >> 2];
  wire wrEn   = wrSel[(uhor_pkg::ADDR_EV_ENABLE - uhor_pkg::BASE_ADDR) >> 2];
  wire wrDis  = wrSel[(uhor_pkg::ADDR_EV_DISABLE - uhor_pkg::BASE_ADDR) >> 2];
  wire wrComm = wrSel[(uhor_pkg::ADDR_COMM_AREA - uhor_pkg::BASE_ADDR) >> 2];
  wire wrCH   = wrSel[(uhor_pkg::ADDR_CTRL_HEAD - uhor_pkg::BASE_ADDR) >> 2];
  wire wrCC   = wrSel[(uhor_pkg::ADDR_CTRL_CUR - uhor_pkg::BASE_ADDR) >> 2];
  wire wrBH   = wrSel[(uhor_pkg::ADDR_BULK_HEAD - uhor_pkg::BASE_ADDR) >> 2];
  wire wrBC   = wrSel[(uhor_pkg::ADDR_BULK_CUR - uhor_pkg::BASE_ADDR) >> 2];
  wire wrFI   = wrSel[(uhor_pkg::ADDR_FR_INTERVAL - uhor_pkg::BASE_ADDR) >> 2];
  wire wrPB   = wrSel[(uhor_pkg::ADDR_PER_BEGIN - uhor_pkg::BASE_ADDR) >> 2];
  wire wrLS   = wrSel[(uhor_pkg::ADDR_LS_THRESH - uhor_pkg::BASE_ADDR) >> 2];
  wire wrDA   = wrSel[(uhor_pkg::ADDR_HUB_DESC_A - uhor_pkg::BASE_ADDR) >> 2];
  wire wrDB   = wrSel[(uhor_pkg::ADDR_HUB_DESC_B - uhor_pkg::BASE_ADDR) >> 2];
  wire wrHub  = wrSel[(uhor_pkg::ADDR_HUB_STATE - uhor_pkg::BASE_ADDR) >> 2];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0]  cmd_q;
  logic [1:0]  overrunCnt_q;
  logic [31:0] status_q;
  logic [31:0] enable_q;
  logic [31:0] perCur_q;
  logic [31:0] ctrlCur_q;
  logic [31:0] doneHead_q;
  logic [13:0] interval_q;
  logic [14:0] pktLimit_q;
  logic        intToggle_q;
  logic [13:0] perBegin_q;
  logic [10:0] lsThresh_q;
  logic [31:0] descA_q;
  logic [31:0] descB_q;
  logic [15:0] hubChange_q;
  logic [31:0] portChangeAll_q;
  logic        fnMsbPrev_q;
  wire  [13:0] remaining;
  wire         remToggle;
  wire  [15:0] frameNum;
  wire         sofPulse;

  wire  [1:0]  fsNow    = control_q[uhor_pkg::CTL_FS_LSB +: 2];
  wire  [1:0]  fsWr     = regWdata[uhor_pkg::CTL_FS_LSB +: 2];
  wire         runFr    = fsNow == uhor_pkg::FS_OPER;
  wire         swReset  = cmd_q[uhor_pkg::CMD_RESET_BIT];
  wire         resumeGo = resumeDetected && fsNow == uhor_pkg::FS_SUSPEND;
  wire         fnoEvent = frameNum[15] != fnMsbPrev_q;
  wire         hubEvent = |hubChangeIn || |portChangeIn;
  wire  [31:0] evSet    = ({31'h0, overrunEvent} << uhor_pkg::EV_SO)
                        | ({31'h0, doneWe} << uhor_pkg::EV_WDH)
                        | ({31'h0, sofPulse} << uhor_pkg::EV_SF)
                        | ({31'h0, resumeGo} << uhor_pkg::EV_RD)
                        | ({31'h0, errorEvent} << uhor_pkg::EV_UE)
                        | ({31'h0, fnoEvent} << uhor_pkg::EV_FNO)
                        | ({31'h0, hubEvent} << uhor_pkg::EV_RHSC)
                        | ({31'h0, wrCmd && regWdata[uhor_pkg::CMD_OCR_BIT]} << uhor_pkg::EV_OC);
  wire  [31:0] evClr    = wrSts ? regWdata & uhor_pkg::EV_MASK : 32'h0;
  wire  [31:0] enSet    = wrEn ? regWdata & uhor_pkg::EN_MASK : 32'h0;
  wire  [31:0] enClr    = wrDis ? regWdata & uhor_pkg::EN_MASK : 32'h0;
  wire  [31:0] hubCtl   = {16'h0, hubChangeIn};
  wire         irqNext  = enable_q[uhor_pkg::EV_MASTER]
                       && |(status_q & enable_q & uhor_pkg::EV_MASK);

  // ----------------------------------------------------------------
  // Control and command words
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      control_q <= 11'h000;
    end else if (swReset) begin
      control_q <= (control_q & uhor_pkg::CTL_KEEP_MASK)
                 | (11'(uhor_pkg::FS_SUSPEND) << uhor_pkg::CTL_FS_LSB);
    end else if (wrCtl) begin
      control_q <= regWdata[uhor_pkg::CTL_W-1:0];
    end else if (resumeGo) begin
      control_q[uhor_pkg::CTL_FS_LSB +: 2] <= uhor_pkg::FS_RESUME;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_q        <= 4'h0;
      overrunCnt_q <= 2'h0;
      softReset_q  <= 1'b0;
    end else begin
      softReset_q <= swReset;
      cmd_q[uhor_pkg::CMD_RESET_BIT] <= wrCmd && regWdata[uhor_pkg::CMD_RESET_BIT];
      cmd_q[uhor_pkg::CMD_CLF_BIT] <= (wrCmd && regWdata[uhor_pkg::CMD_CLF_BIT])
                                   || (cmd_q[uhor_pkg::CMD_CLF_BIT] && !clfClear);
      cmd_q[uhor_pkg::CMD_BLF_BIT] <= (wrCmd && regWdata[uhor_pkg::CMD_BLF_BIT])
                                   || (cmd_q[uhor_pkg::CMD_BLF_BIT] && !blfClear);
      cmd_q[uhor_pkg::CMD_OCR_BIT] <= (wrCmd && regWdata[uhor_pkg::CMD_OCR_BIT])
                                   || (cmd_q[uhor_pkg::CMD_OCR_BIT] && !ownershipTaken);
      if (overrunEvent) begin
        overrunCnt_q <= overrunCnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status, enable, interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || swReset) begin
      status_q    <= 32'h0;
      enable_q    <= 32'h0;
      irq_q       <= 1'b0;
      fnMsbPrev_q <= 1'b0;
    end else begin
      status_q    <= (status_q & ~evClr) | evSet;
      enable_q    <= (enable_q & ~enClr) | enSet;
      irq_q       <= irqNext;
      fnMsbPrev_q <= frameNum[15];
    end
  end

  // ----------------------------------------------------------------
  // Memory pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      commArea_q <= 32'h0;
      perCur_q   <= 32'h0;
      ctrlHead_q <= 32'h0;
      ctrlCur_q  <= 32'h0;
      bulkHead_q <= 32'h0;
      bulkCur_q  <= 32'h0;
      doneHead_q <= 32'h0;
    end else begin
      if (wrComm) commArea_q <= regWdata & uhor_pkg::COMM_AREA_MASK;
      if (perCurWe) perCur_q <= engineAddr & uhor_pkg::DESC_PTR_MASK;
      if (wrCH) ctrlHead_q <= regWdata & uhor_pkg::DESC_PTR_MASK;
      if (ctrlCurWe) begin
        ctrlCur_q <= engineAddr & uhor_pkg::DESC_PTR_MASK;
      end else if (wrCC) begin
        ctrlCur_q <= regWdata & uhor_pkg::DESC_PTR_MASK;
      end
      if (wrBH) bulkHead_q <= regWdata & uhor_pkg::DESC_PTR_MASK;
      if (bulkCurWe) begin
        bulkCur_q <= engineAddr & uhor_pkg::DESC_PTR_MASK;
      end else if (wrBC) begin
        bulkCur_q <= regWdata & uhor_pkg::DESC_PTR_MASK;
      end
      if (doneWe) doneHead_q <= engineAddr & uhor_pkg::DESC_PTR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  uhor_frame_timer #(
    .START_DELAY (START_DELAY)
  ) u_timer (
    .clock          (clock),
    .reset          (reset || swReset),
    .run            (runFr),
    .interval       (interval_q),
    .intervalToggle (intToggle_q),
    .remaining_q    (remaining),
    .remToggle_q    (remToggle),
    .frameNum_q     (frameNum),
    .sofPulse_q     (sofPulse)
  );

  always_ff @(posedge clock) begin
    if (reset || swReset) begin
      interval_q  <= uhor_pkg::FI_RESET;
      pktLimit_q  <= uhor_pkg::PKT_RESET;
      intToggle_q <= 1'b0;
      perBegin_q  <= uhor_pkg::PER_RESET;
      lsThresh_q  <= uhor_pkg::LS_RESET;
    end else begin
      if (wrFI) begin
        interval_q  <= regWdata[uhor_pkg::FI_W-1:0];
        pktLimit_q  <= regWdata[uhor_pkg::PKT_LSB +: uhor_pkg::PKT_W];
        intToggle_q <= regWdata[uhor_pkg::TOGGLE_BIT];
      end
      if (wrPB) perBegin_q <= regWdata[uhor_pkg::FI_W-1:0];
      if (wrLS) lsThresh_q <= regWdata[uhor_pkg::LS_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sofPulse_q          <= 1'b0;
      periodicAllowed_q   <= 1'b0;
      slowCommitAllowed_q <= 1'b0;
    end else begin
      sofPulse_q          <= sofPulse;
      periodicAllowed_q   <= runFr && remaining <= perBegin_q;
      slowCommitAllowed_q <= runFr && remaining > 14'(lsThresh_q);
    end
  end

  // ----------------------------------------------------------------
  // Root hub
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      descA_q     <= 32'h0;
      descB_q     <= 32'h0;
      hubChange_q <= 16'h0;
      hubCmd_q    <= 16'h0;
    end else begin
      if (wrDA) descA_q <= regWdata & uhor_pkg::HUB_DESC_A_MASK;
      if (wrDB) descB_q <= regWdata;
      hubChange_q <= (hubChange_q & ~(wrHub ? regWdata[31:16] : 16'h0))
                   | hubCtl[15:0];
      hubCmd_q    <= wrHub ? regWdata[15:0] : 16'h0;
    end
  end

  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      wire portWr = wrSel[((uhor_pkg::ADDR_PORT_FIRST - uhor_pkg::BASE_ADDR) >> 2) + gi];
      always_ff @(posedge clock) begin
        if (reset) begin
          portChangeAll_q[gi*16 +: 16] <= 16'h0;
          portCmd_q[gi*16 +: 16]       <= 16'h0;
        end else begin
          portChangeAll_q[gi*16 +: 16] <= (portChangeAll_q[gi*16 +: 16]
                                          & ~(portWr ? regWdata[31:16] : 16'h0))
                                          | portChangeIn[gi*16 +: 16];
          portCmd_q[gi*16 +: 16]       <= portWr ? regWdata[15:0] : 16'h0;
        end
      end
      assign word[21 + gi] = {portChangeAll_q[gi*16 +: 16], portStatusIn[gi*16 +: 16]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  assign word[0]  = {uhor_pkg::VERSION_VALUE, 8'h00};
  assign word[1]  = {21'h0, control_q};
  assign word[2]  = {14'h0, overrunCnt_q, 12'h0, cmd_q};
  assign word[3]  = status_q;
  assign word[4]  = enable_q;
  assign word[5]  = enable_q;
  assign word[6]  = commArea_q;
  assign word[7]  = perCur_q;
  assign word[8]  = ctrlHead_q;
  assign word[9]  = ctrlCur_q;
  assign word[10] = bulkHead_q;
  assign word[11] = bulkCur_q;
  assign word[12] = doneHead_q;
  assign word[13] = {intToggle_q, pktLimit_q, 2'h0, interval_q};
  assign word[14] = {remToggle, 17'h0, remaining};
  assign word[15] = {16'h0, frameNum};
  assign word[16] = {18'h0, perBegin_q};
  assign word[17] = {21'h0, lsThresh_q};
  assign word[18] = {descA_q[31:8], 8'(NP)};
  assign word[19] = descB_q;
  assign word[20] = {hubChange_q, hubStatusIn};

  wire [31:0] readWord = hit ? word[wordIdx[uhor_pkg::IDX_W-1:0]] : 32'h0;

  always_ff @(posedge clock) begin
    if (reset) begin
      regRdata_q <= 32'h0;
    end else if (regRead) begin
      regRdata_q <= readWord;
    end
  end
endmodule

// ---- test/uhor_regs_chk.sv ----
`timescale 1ns/1ps
module uhor_regs_chk (
  // Bus
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [31:0] regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regWdata,
  // State
  input wire logic [31:0] regRdata_q,
  input wire logic [10:0] control_q,
  input wire logic        softReset_q,
  input wire logic        irq_q,
  input wire logic        sofPulse_q,
  input wire logic        periodicAllowed_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic isOper;
  assign isOper = control_q[7:6] == 2'h2;
  a_version_read: assert property (regRead && regAddr == 32'h30002c00 |=>
    regRdata_q == {uhor_pkg::VERSION_VALUE, 8'h00}) else $error("bad version");
  a_bad_addr: assert property (regRead && (regAddr[1:0] != 2'h0 ||
    regAddr == 32'h30002c5c) |=> regRdata_q == 32'h0) else $error("bad empty read");
  a_rdata_hold: assert property (!regRead |=> $stable(regRdata_q))
    else $error("read data moved");
  a_irq_disable: assert property (regWrite && regAddr == 32'h30002c14 &&
    regWdata[31] |-> ##2 !irq_q) else $error("irq not masked");
  a_sof_delay: assert property (isOper && !$past(isOper) |->
    !sofPulse_q [*8]) else $error("early frame start");
  a_periodic_gate: assert property (!isOper [*2] |-> !periodicAllowed_q)
    else $error("periodic outside frames");
  a_soft_reset: assert property (regWrite && regAddr == 32'h30002c08 &&
    regWdata[0] |-> ##[1:3] softReset_q && control_q[7:6] == 2'h3) else $error("no reset");
  a_state_write: assert property (regWrite && regAddr == 32'h30002c04 |=>
    control_q[7:6] == $past(regWdata[7:6])) else $error("state not taken");
endmodule
bind uhor_regs uhor_regs_chk uhor_regs_chk_i (.clock, .reset, .regAddr, .regWrite,
  .regRead, .regWdata, .regRdata_q, .control_q, .softReset_q, .irq_q, .sofPulse_q,
  .periodicAllowed_q);

// ---- test/uhor_usb_dev.sv ----
`timescale 1ns/1ps
module uhor_usb_dev (
  // Clock and attach
  input  wire logic        clock,
  input  wire logic        plug,
  // Hub and port lines
  output logic      [15:0] hubSt,
  output logic      [15:0] hubChg,
  output logic      [31:0] portSt,
  output logic      [31:0] portChg
);
  logic plug_q = 1'b0;
  always @(posedge clock) plug_q <= plug;
  assign hubSt = {15'h0, plug_q};
  assign hubChg = {15'h0, plug && !plug_q};
  assign portSt = {16'h0100, 15'h0, plug_q};
  assign portChg = {31'h0, plug && !plug_q};
endmodule

// ---- test/tb_uhor_regs.sv ----
`timescale 1ns/1ps
module tb_uhor_regs;
  logic        clock = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, plug = 1'b0;
  logic [9:0]  p = 10'h0;
  logic [31:0] regAddr = 32'h0, regWdata = 32'h0, engineAddr = 32'habcdef1f;
  logic [31:0] regRdata_q, portSt, portChg;
  logic [15:0] hubSt, hubChg;
  logic [10:0] control_q;
  logic        irq_q, sofPulse_q, pa, sca;
  logic [7:0]  engOff [3] = '{8'h1c, 8'h2c, 8'h30};
  int          failures = 0;
  int          compares = 0;
  always #10 clock = ~clock;
  uhor_usb_dev uhor_usb_dev_i (.clock, .plug, .hubSt, .hubChg, .portSt, .portChg);
  uhor_regs #(.START_DELAY(20)) uhor_regs_i (.clock, .reset, .regAddr, .regWrite, .regRead,
    .regWdata, .regRdata_q, .perCurWe(p[0]), .bulkCurWe(p[1]), .doneWe(p[2]),
    .ctrlCurWe(p[3]), .engineAddr, .clfClear(p[4]), .blfClear(p[5]), .ownershipTaken(p[6]),
    .overrunEvent(p[7]), .errorEvent(p[8]), .resumeDetected(p[9]), .hubStatusIn(hubSt),
    .hubChangeIn(hubChg), .portStatusIn(portSt), .portChangeIn(portChg), .hubCmd_q(),
    .portCmd_q(), .control_q, .softReset_q(), .irq_q, .sofPulse_q,
    .periodicAllowed_q(pa), .slowCommitAllowed_q(sca), .commArea_q(), .ctrlHead_q(),
    .bulkHead_q(), .bulkCur_q());
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= {24'h30002c, a};
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= {24'h30002c, a};
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    chk($sformatf("register %h", a), regRdata_q, e);
  endtask
  task automatic pulse(input int i);
    p[i] <= 1'b1;
    @(posedge clock);
    p <= 10'h0;
    @(posedge clock);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    wr(8'h00, 32'hffffffff);
    rd(8'h00, {uhor_pkg::VERSION_VALUE, 8'h00});
    rd(8'h34, 32'h00002edf);
    rd(8'h44, 32'h00000628);
    wr(8'h5c, 32'hffffffff);
    rd(8'h5c, 32'h0);
    rd(8'h02, 32'h0);
    wr(8'h18, 32'hffffffff);
    rd(8'h18, 32'hffffff00);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h00003fff);
    wr(8'h20, 32'h12345678);
    rd(8'h20, 32'h12345670);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      rd(engOff[i], 32'habcdef10);
    end
    wr(8'h10, 32'h80000001);
    pulse(7);
    @(posedge clock);
    chk("interrupt", {31'h0, irq_q}, 32'h1);
    pulse(8);
    rd(8'h0c, 32'h00000013);
    wr(8'h14, 32'h80000000);
    rd(8'h10, 32'h00000001);
    chk("interrupt", {31'h0, irq_q}, 32'h0);
    wr(8'h0c, 32'h00000013);
    rd(8'h0c, 32'h0);
    plug <= 1'b1;
    repeat (2) @(posedge clock);
    rd(8'h50, 32'h00010001);
    rd(8'h54, 32'h00010001);
    rd(8'h58, 32'h00000100);
    wr(8'h04, 32'h00000080);
    rd(8'h04, 32'h00000080);
    for (int k = 0; k < 200 && sofPulse_q !== 1'b1; k++) @(posedge clock);
    if (sofPulse_q === 1'b1) begin
      rd(8'h3c, 32'h00000001);
      chk("frame gates", {30'h0, pa, sca}, 32'h3);
      wr(8'h08, 32'h00000001);
      rd(8'h04, 32'h000000c0);
      rd(8'h34, 32'h00002edf);
      pulse(9);
      rd(8'h04, 32'h00000040);
      rd(8'h0c, 32'h00000008);
    end else begin
      failures++;
    end
    conclude();
  end
endmodule
